// ===== hw/capwm_top.sv
// holds the center-aligned pwm channel with its counter and an apb register slave
// assumes a synchronous apb master on SYS_CLK and a load driven by PWM_OUT
//
// Notes on behaviour
// - center-align select makes the counter count up and down, output center-aligned
// - counter counts up to modulus, then down to zero, and repeats
// - center-aligned period is twice the modulus in counter ticks
// - center-aligned pulse width is twice a compare value below the modulus, in counter ticks
// - polarity clear: match counting up drives low, counting down drives high
// - compare zero or with bit 15 set gives 0% duty
// - positive compare above nonzero modulus never matches, giving 100% duty
// - edge mode with modulus zero runs the counter through full 16 bits
// - direction turns down only on a modulus match at a nonzero count
// - free-running counter loads buffered values as count goes 0xFFFE to 0xFFFF
`timescale 1ns/10ps
`include "capwm_params.svh"

module capwm_top
#(
   parameter int WIDTH = 16
)
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic PWM_OUT
);

   // =====================================================
   // register state
   logic center_align_select;
   logic output_polarity_select;
   logic enable;
   logic [WIDTH-1:0] counter_modulus;
   logic [WIDTH-1:0] channel_compare_value;
   logic [WIDTH-1:0] mod_buf;
   logic [WIDTH-1:0] cmp_buf;
   logic update_pending;
   logic [WIDTH-1:0] count;
   capwm_pkg::capwm_dir_type dir;
   logic [WIDTH-1:0] next_count;
   capwm_pkg::capwm_dir_type next_dir;
   logic load_now;
   logic apb_access;
   logic apb_write;
   logic addr_ok;

   assign apb_access = PSEL && PENABLE && !PREADY;
   assign apb_write = apb_access && PWRITE;
   assign addr_ok = (PADDR == `CAPWM_ADDR_CTRL) || (PADDR == `CAPWM_ADDR_MOD) ||
                    (PADDR == `CAPWM_ADDR_CMP) || (PADDR == `CAPWM_ADDR_CNT) ||
                    (PADDR == `CAPWM_ADDR_STAT);

   // =====================================================
   // apb handshake: one wait state, ready pulses for one cycle
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY <= apb_access;
         PSLVERR <= apb_access && !addr_ok;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         PRDATA <= 32'h00000000;
      end
      else if (apb_access && !PWRITE)
      begin
         case (PADDR)
            `CAPWM_ADDR_CTRL: PRDATA <= {29'h00000000, enable, output_polarity_select,
                                         center_align_select};
            `CAPWM_ADDR_MOD: PRDATA <= {16'h0000, counter_modulus};
            `CAPWM_ADDR_CMP: PRDATA <= {16'h0000, channel_compare_value};
            `CAPWM_ADDR_CNT: PRDATA <= {16'h0000, count};
            `CAPWM_ADDR_STAT: PRDATA <= {29'h00000000, update_pending, PWM_OUT, dir};
            default: PRDATA <= 32'h00000000;
         endcase
      end
      else
      begin
         PRDATA <= 32'h00000000;
      end
   end

   // =====================================================
   // control register
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         {enable, output_polarity_select, center_align_select} <= `CAPWM_RST_CTRL;
      end
      else if (apb_write && PADDR == `CAPWM_ADDR_CTRL)
      begin
         center_align_select <= PWDATA[`CAPWM_CTRL_CENTER];
         output_polarity_select <= PWDATA[`CAPWM_CTRL_POL];
         enable <= PWDATA[`CAPWM_CTRL_ENABLE];
      end
   end

   // =====================================================
   // buffered modulus and compare; writes wait in the buffer until a load point
   // so a period is never cut short by a mid-cycle change
   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         mod_buf <= `CAPWM_RST_MOD;
         cmp_buf <= `CAPWM_RST_CMP;
         update_pending <= 1'b0;
      end
      else
      begin
         if (apb_write && PADDR == `CAPWM_ADDR_MOD)
         begin
            mod_buf <= PWDATA[WIDTH-1:0];
         end
         if (apb_write && PADDR == `CAPWM_ADDR_CMP)
         begin
            cmp_buf <= PWDATA[WIDTH-1:0];
         end
         // a new write in the load cycle keeps the flag set
         if (apb_write && (PADDR == `CAPWM_ADDR_MOD || PADDR == `CAPWM_ADDR_CMP))
         begin
            update_pending <= 1'b1;
         end
         else if (load_now)
         begin
            update_pending <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         counter_modulus <= `CAPWM_RST_MOD;
         channel_compare_value <= `CAPWM_RST_CMP;
      end
      else if (load_now)
      begin
         counter_modulus <= mod_buf;
         channel_compare_value <= cmp_buf;
      end
   end

   // =====================================================
   // counter next state
   always_comb
   begin
      next_count = count;
      next_dir = dir;
      load_now = 1'b0;
      if (!enable)
      begin
         next_count = '0;
         next_dir = capwm_pkg::CAPWM_DIR_UP;
         load_now = update_pending;
      end
      else if (center_align_select)
      begin
         if (dir == capwm_pkg::CAPWM_DIR_UP)
         begin
            if (count == counter_modulus && count != '0)
            begin
               next_dir = capwm_pkg::CAPWM_DIR_DOWN;
               next_count = count - 1'b1;
            end
            else
            begin
               next_count = count + 1'b1;
            end
         end
         else if (count == '0)
         begin
            next_dir = capwm_pkg::CAPWM_DIR_UP;
            next_count = count + 1'b1;
            load_now = update_pending; // period boundary at zero
         end
         else
         begin
            next_count = count - 1'b1;
         end
      end
      else
      begin
         next_dir = capwm_pkg::CAPWM_DIR_UP;
         if (counter_modulus == '0)
         begin
            next_count = count + 1'b1;
            load_now = update_pending && count == `CAPWM_CNT_FREE_LOAD;
         end
         else if (count >= counter_modulus)
         begin
            next_count = '0;
            load_now = update_pending;
         end
         else
         begin
            next_count = count + 1'b1;
         end
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         count <= '0;
         dir <= capwm_pkg::CAPWM_DIR_UP;
      end
      else
      begin
         count <= next_count;
         dir <= next_dir;
      end
   end

   // =====================================================
   // output: level is set by the compare so that, for a compare below modulus, it is high for 2 x compare ticks
   // around count zero; comparing by sign and magnitude covers the 0% and 100% corners
   logic cmp_neg;
   logic active;
   logic below_cmp;
   logic at_cmp_down;
   assign cmp_neg = channel_compare_value[WIDTH-1];

   // =====================================================
   // compare against the count of the coming cycle, so the registered pin
   // lines up with the count it belongs to
   assign below_cmp = next_count < channel_compare_value;

   // the down-count match sets the level at the match count itself, while the
   // up-count match clears it there; this asymmetry gives exactly 2 x compare ticks when compare is below modulus
   assign at_cmp_down = (next_count == channel_compare_value) &&
                        (next_dir == capwm_pkg::CAPWM_DIR_DOWN);

   always_comb
   begin
      if (cmp_neg || channel_compare_value == '0)
      begin
         active = 1'b0;
      end
      else if (channel_compare_value > counter_modulus)
      begin
         active = 1'b1;
      end
      else if (next_dir == capwm_pkg::CAPWM_DIR_UP)
      begin
         // up-count match drives the active level off
         active = below_cmp;
      end
      else
      begin
         // down-count match drives the active level on
         active = below_cmp || at_cmp_down;
      end
   end

   always_ff @(posedge SYS_CLK)
   begin
      if (RESET)
      begin
         PWM_OUT <= 1'b0;
      end
      else if (!enable || !center_align_select)
      begin
         PWM_OUT <= output_polarity_select; // idle at inactive level
      end
      else
      begin
         PWM_OUT <= active ^ output_polarity_select;
      end
   end

endmodule : capwm_top

// ===== inc/capwm_params.svh
// holds the register offsets, field positions, reset values and counts of the pwm channel
// assumes inclusion by bare name from the design module
`ifndef CAPWM_PARAMS_SVH
`define CAPWM_PARAMS_SVH

// =====================================================
// register byte offsets
`define CAPWM_ADDR_CTRL 12'h000
`define CAPWM_ADDR_MOD 12'h004
`define CAPWM_ADDR_CMP 12'h008
`define CAPWM_ADDR_CNT 12'h00C
`define CAPWM_ADDR_STAT 12'h010

// =====================================================
// control field positions
`define CAPWM_CTRL_CENTER 0
`define CAPWM_CTRL_POL 1
`define CAPWM_CTRL_ENABLE 2

// =====================================================
// reset values and counter constants
`define CAPWM_RST_CTRL 3'h0
`define CAPWM_RST_MOD 16'h0000
`define CAPWM_RST_CMP 16'h0000
`define CAPWM_CNT_FREE_LOAD 16'hFFFE

`endif

// ===== inc/capwm_pkg.sv
// holds the direction type used by the pwm channel design
// assumes the constants header is on the include path
package capwm_pkg;

   // =====================================================
   // counting direction
   typedef enum logic [0:0]
   {
      CAPWM_DIR_UP = 1'b0,
      CAPWM_DIR_DOWN = 1'b1
   } capwm_dir_type;

endpackage : capwm_pkg

// ===== verif/capwm_load.sv
// load on the pwm pin: keeps the length of the last high and low run
// assumes the pin only changes on rising SYS_CLK edges
`timescale 1ns/10ps
module capwm_load
(
   input wire logic clk,
   input wire logic pwm,
   output int hi_len,
   output int lo_len
);
   int run = 0;
   logic last = 1'b0;
   // ==========
   // run lengths, seen as a motor drive would
   always @(posedge clk)
   begin
      run <= (pwm === last) ? run + 1 : 1;
      last <= pwm;
      if (pwm !== last && last) hi_len <= run;
      if (pwm !== last && !last) lo_len <= run;
   end
endmodule : capwm_load

// ===== verif/capwm_top_asserts.sv
// checker on the ports of the pwm channel top
// assumes binding onto capwm_top
`timescale 1ns/10ps
module capwm_top_asserts
(
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic PWM_OUT
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RESET);
   // ==========
   // bus answer timing and data, and idle outputs after reset
   a_ready_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
      else $error("no answer one cycle after access");
   a_ready_pulse: assert property (PREADY |=> !PREADY)
      else $error("ready longer than one cycle");
   a_ready_cause: assert property (PREADY |-> $past(PSEL && PENABLE))
      else $error("ready without access");
   a_err_quiet: assert property (PSLVERR |-> PREADY)
      else $error("error outside answer");
   a_rdata_quiet: assert property (!PREADY |-> PRDATA == 32'h0)
      else $error("read data outside answer");
   a_err_map: assert property (PREADY && PADDR > 12'h010 |-> PSLVERR)
      else $error("unmapped access not refused");
   a_upper_zero: assert property (PREADY |-> PRDATA[31:16] == 16'h0000)
      else $error("upper read bits set");
   a_reset_idle: assert property ($fell(RESET) |-> !PWM_OUT && !PREADY)
      else $error("outputs not idle after reset");
   cover property (PREADY && PSLVERR);
   cover property (PREADY && PWRITE);
   cover property ($rose(PWM_OUT));
endmodule : capwm_top_asserts

// ===== verif/test_center_aligned_pwm.sv
// bench for the center-aligned pwm channel over apb
// assumes capwm_top, capwm_load and the checker are compiled first
`timescale 1ns/10ps
module test_center_aligned_pwm;
   logic SYS_CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
   logic [11:0] PADDR = 12'h000;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic PREADY, PSLVERR, PWM_OUT, err;
   int hi_len, lo_len, n_errors = 0, checks = 0, cyc = 0, seed = 32'heea2, m;
   logic [15:0] c;
   capwm_top dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));
   capwm_load load_u (.clk(SYS_CLK), .pwm(PWM_OUT), .hi_len(hi_len), .lo_len(lo_len));
   // ==========
   // clock and hang guard
   initial
   begin
      forever #5 SYS_CLK = ~SYS_CLK;
   end
   always @(posedge SYS_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 90000)
      begin
         n_errors++;
         close_out();
      end
   end
   // ==========
   // tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) n_errors++;
      if (got !== exp) $display("MISMATCH %0t got %h exp %h", $time, got, exp);
   endtask : check
   // master holds the request until ready is sampled high, giving up after 20 cycles
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      PSEL <= 1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge SYS_CLK) PENABLE <= 1;
      do @(posedge SYS_CLK); while (PREADY !== 1'b1 && ++k < 20);
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 0;
      PENABLE <= 0;
      @(posedge SYS_CLK);
   endtask : apb
   // high time per period; polarity set swaps high and low
   function automatic int high_time(input int m, input int c, input logic p);
      return p ? 2 * (m - c) : 2 * c;
   endfunction : high_time
   task automatic run(input int m, input logic [15:0] c, input logic p);
      apb(1, 12'h004, m);
      apb(1, 12'h008, {16'h0, c});
      apb(1, 12'h000, {29'h0, 1'b1, p, 1'b1});
      repeat (6 * m + 200) @(posedge SYS_CLK);
      apb(0, 12'h008, 0);
      check(rd, {16'h0, c});
      if (c == 0 || c[15] || c > m)
         repeat (4) @(posedge SYS_CLK) check(PWM_OUT, p ^ (c > m && !c[15]));
      else
      begin
         check(hi_len, high_time(m, c, p));
         check(lo_len, 2 * m - high_time(m, c, p));
      end
      $display("run mod %0d cmp %0h pol %0d done", m, c, p);
   endtask : run
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : close_out
   // ==========
   // main sequence
   initial
   begin
      repeat (12) @(posedge SYS_CLK);
      RESET <= 0;
      @(posedge SYS_CLK);
      apb(0, 12'h000, 0);
      check(rd, 0);
      apb(0, 12'h004, 0);
      check(rd, 0);
      apb(0, 12'h020, 0);
      check({31'h0, err}, 1);
      for (int i = 0; i < 6; i++)
      begin
         m = 2 + {$random(seed)} % 40;
         c = 1 + {$random(seed)} % (m - 1);
         run(m, c, i[0]);
      end
      run(2, 1, 1);
      run(5, 0, 0);
      run(5, 16'h8000, 1);
      run(5, 9, 0);
      apb(1, 12'h000, 0);
      apb(1, 12'h004, 0);
      apb(1, 12'h008, 32'h7);
      apb(1, 12'h000, 32'h4);
      repeat (300) @(posedge SYS_CLK);
      apb(0, 12'h00C, 0);
      check({31'h0, rd >= 300 && rd < 320}, 1);
      apb(1, 12'h008, 32'h33);
      apb(0, 12'h008, 0);
      check(rd, 32'h7);
      repeat (65300) @(posedge SYS_CLK);
      apb(0, 12'h008, 0);
      check(rd, 32'h33);
      $display("free-running load done");
      close_out();
   end
endmodule : test_center_aligned_pwm
bind capwm_top capwm_top_asserts chk_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
   .PSLVERR(PSLVERR), .PWM_OUT(PWM_OUT));
